// [src/ccsd_top.sv]
// Operation
// - Over-current trip in cycle-by-cycle mode brakes bridge until a pin edge or a rising control-bit edge.
// - Brake never ends by itself; only a fresh control edge restores following.
// - With report bit set, fault pin goes low during regulation brake.
// - Regulation indication changes nothing and arises only from forward or reverse drive.
// - Stall compare uses external or fixed internal reference by select bit.
// - Stall flag sets on detection only while stall detection is enabled.
// - Stall disabled with mode 01b regulates whenever sense reaches reference.
// - Stall compare ignored during blanking, flagged at first hit afterwards.
// - Blanking is 5 ms plus 102.4 us per setting step, default 1 s.
// - Soft-start ramps level over blanking interval; software scales setting.
// - Blanking restarts at power-up, fault recovery, sleep exit, stall recovery.
// - Response bit 0b: stall latches bridge off and sets stall flag.
// - Response bit 1b: stall sets flag while bridge keeps driving.
// - Writing clear bit drops stall flag and reruns blanking before detection.
// - Report bit 1b drives fault pin low while stall is flagged.
// - Mode field: 00b none, 01b during blanking with stall on, 10b always.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ccsd_top
  import ccsd_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BLANK_BASE_CYC,
  parameter int unsigned LSB_CYCLES  = BLANK_LSB_CYC
)
(
  // Clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  // Control pins and analog comparators
  input  wire logic              DRIVE_INPUT_A_IN,
  input  wire logic              DRIVE_INPUT_B_IN,
  input  wire logic              TRIP_IN,
  input  wire logic              SENSE_GE_EXT_REF_IN,
  input  wire logic              SENSE_GE_INT_REF_IN,
  // Bridge and status pins
  output logic [1:0]             BRIDGE_HI_OUT,
  output logic [1:0]             BRIDGE_LO_OUT,
  output logic                   FAULT_OUT_N_OUT,
  output logic [15:0]            SOFTSTART_LEVEL_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              awfull_q, awfull_d;
  logic              wfull_q,  wfull_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q,  wdata_d;
  logic [3:0]        wstrb_q,  wstrb_d;
  logic              awrdy_q,  awrdy_d;
  logic              wrdy_q,   wrdy_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q,  bresp_d;
  logic              arrdy_q,  arrdy_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q,  rdata_d;
  logic [1:0]        rresp_q,  rresp_d;
  logic [31:0]       ctrl_q,   ctrl_d;
  logic [31:0]       blank_q,  blank_d;
  logic              clr_q,    clr_d;
  logic [31:0]       status;

  ccsd_reg_state_t   st_q,     st_d;
  logic              stall_q,  stall_d;
  logic              sleep_q,  sleep_d;
  logic              drv_q,    drv_d;
  logic [15:0]       ramp_q,   ramp_d;
  logic [1:0]        hi_q,     hi_d;
  logic [1:0]        lo_q,     lo_d;
  logic              fltn_q,   fltn_d;

  ccsd_bridge_t      cmd;
  logic              ctrl_edge;
  logic              drive_state;
  logic              reg_allowed;
  logic              trip_go;
  logic              stall_hit;
  logic              stall_off;
  logic [1:0]        mode;
  logic [15:0]       blank_set;

  ccsd_blank_if blk ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  ccsd_blank_timer #(
    .BASE_CYCLES (BASE_CYCLES),
    .LSB_CYCLES  (LSB_CYCLES)
  ) u_blank (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .blk      (blk)
  );

  ccsd_ctrl_edge u_edge (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .pin_a_in (DRIVE_INPUT_A_IN),
    .pin_b_in (DRIVE_INPUT_B_IN),
    .bit_a_in (ctrl_q[CTRL_SOFT_A]),
    .bit_b_in (ctrl_q[CTRL_SOFT_B]),
    .edge_out (ctrl_edge)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave and register file
  // ----------------------------------------------------------------
  always_comb
  begin
    awfull_d = awfull_q;
    wfull_d  = wfull_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    ctrl_d   = ctrl_q;
    blank_d  = blank_q;
    clr_d    = 1'b0;
    if (S_AXI_AWVALID_IN && awrdy_q)
    begin
      awfull_d = 1'b1;
      awaddr_d = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && wrdy_q)
    begin
      wfull_d = 1'b1;
      wdata_d = S_AXI_WDATA_IN;
      wstrb_d = S_AXI_WSTRB_IN;
    end
    if (bvalid_q && S_AXI_BREADY_IN)
      bvalid_d = 1'b0;
    // Both halves are held, so the write lands once per transaction.
    if (awfull_q && wfull_q && !bvalid_q)
    begin
      awfull_d = 1'b0;
      wfull_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      unique case (awaddr_q)
        ADDR_CTRL:
          for (int i = 0; i < 4; i++)
            if (wstrb_q[i])
              ctrl_d[8*i +: 8] = wdata_q[8*i +: 8];
        ADDR_BLANK:
          for (int i = 0; i < 3; i++)
            if (wstrb_q[i])
              blank_d[8*i +: 8] = wdata_q[8*i +: 8];
        ADDR_CMD:
          clr_d = wstrb_q[0] & wdata_q[CMD_CLR_FAULT];
        ADDR_STATUS: ;
        default:
          bresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && S_AXI_RREADY_IN)
      rvalid_d = 1'b0;
    if (S_AXI_ARVALID_IN && arrdy_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (S_AXI_ARADDR_IN)
        ADDR_CTRL:   rdata_d = ctrl_q;
        ADDR_BLANK:  rdata_d = blank_q;
        ADDR_CMD:    rdata_d = 32'h0000_0000;
        ADDR_STATUS: rdata_d = status;
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awrdy_d = !awfull_d && !bvalid_d;
    wrdy_d  = !wfull_d && !bvalid_d;
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      awfull_q <= 1'b0;
      wfull_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      awrdy_q  <= 1'b0;
      wrdy_q   <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
      ctrl_q   <= CTRL_RESET;
      blank_q  <= BLANK_RESET;
      clr_q    <= 1'b0;
    end
    else
    begin
      awfull_q <= awfull_d;
      wfull_q  <= wfull_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      arrdy_q  <= arrdy_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
      ctrl_q   <= ctrl_d;
      blank_q  <= blank_d;
      clr_q    <= clr_d;
    end
  end

  // ----------------------------------------------------------------
  // Bridge regulation and stall response
  // ----------------------------------------------------------------
  always_comb
  begin
    mode      = ctrl_q[CTRL_MODE_LO +: 2];
    blank_set = blank_q[BLANK_SET_LO +: 16];
    cmd       = ccsd_bridge_t'({DRIVE_INPUT_B_IN | ctrl_q[CTRL_SOFT_B],
                                DRIVE_INPUT_A_IN | ctrl_q[CTRL_SOFT_A]});
    drive_state = (cmd == BR_FWD) || (cmd == BR_REV);
    // Stall enabled in mode 01b limits regulation to the blanking window.
    if (mode == MODE_OFF)
      reg_allowed = 1'b0;
    else if (mode == MODE_INRUSH)
      reg_allowed = !ctrl_q[CTRL_STALL_EN] || blk.busy;
    else
      reg_allowed = 1'b1;
    // Trip is already conditioned in the analog front end.
    trip_go   = ctrl_q[CTRL_CBC_EN] && reg_allowed && TRIP_IN && drive_state;
    stall_hit = ctrl_q[CTRL_STALL_EN] && !blk.busy
             && (ctrl_q[CTRL_INT_REF] ? SENSE_GE_INT_REF_IN : SENSE_GE_EXT_REF_IN);
    stall_off = stall_hit && !ctrl_q[CTRL_BLK_RESP];
    // A detection in the clearing cycle keeps the flag set.
    stall_d   = stall_hit || (stall_q && !clr_q);
    sleep_d   = ctrl_q[CTRL_SLEEP];
    drv_d     = drive_state;
    st_d      = st_q;
    unique case (st_q)
      RS_FOLLOW:
        if (stall_off)
          st_d = RS_STALL_OFF;
        else if (trip_go && !ctrl_edge)
          st_d = RS_BRAKE;
      RS_BRAKE:
        if (stall_off)
          st_d = RS_STALL_OFF;
        else if (ctrl_edge)
          st_d = RS_FOLLOW;
      RS_STALL_OFF:
        if (clr_q && !stall_hit)
          st_d = RS_FOLLOW;
      default:
        st_d = RS_FOLLOW;
    endcase
    // Blanking reruns on clear, on sleep exit, and at each soft-start swing.
    blk.start   = clr_q || (sleep_q && !ctrl_q[CTRL_SLEEP])
               || (ctrl_q[CTRL_SS_EN] && (drive_state != drv_q));
    blk.setting = blank_set;
    // The ramp climbs one step per interval step, so it reaches the setting value as blanking ends.
    ramp_d = ramp_q;
    if (!ctrl_q[CTRL_SS_EN])
      ramp_d = drive_state ? 16'hffff : 16'h0000;
    else if (blk.tick && drive_state && (ramp_q < blank_set))
      ramp_d = ramp_q + 16'h0001;
    else if (blk.tick && !drive_state && (ramp_q != 16'h0000))
      ramp_d = ramp_q - 16'h0001;
    hi_d = 2'b00;
    lo_d = 2'b00;
    if (ctrl_q[CTRL_SLEEP] || (st_d == RS_STALL_OFF))
      lo_d = 2'b00;
    else if (st_d == RS_BRAKE)
      lo_d = 2'b11;
    else
    begin
      // Indication-only stalls fall through here and keep driving.
      unique case (cmd)
        BR_COAST: lo_d = 2'b00;
        BR_FWD:
        begin
          hi_d = 2'b01;
          lo_d = 2'b10;
        end
        BR_REV:
        begin
          hi_d = 2'b10;
          lo_d = 2'b01;
        end
        BR_BRAKE: lo_d = 2'b11;
      endcase
    end
    // The indication is pure reporting and never feeds back into the bridge.
    fltn_d = !(((st_d == RS_BRAKE) && ctrl_q[CTRL_REG_REP])
            || (stall_d && ctrl_q[CTRL_BLK_REP]));
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      st_q    <= RS_FOLLOW;
      stall_q <= 1'b0;
      sleep_q <= 1'b0;
      drv_q   <= 1'b0;
      ramp_q  <= 16'h0000;
      hi_q    <= 2'b00;
      lo_q    <= 2'b00;
      fltn_q  <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      stall_q <= stall_d;
      sleep_q <= sleep_d;
      drv_q   <= drv_d;
      ramp_q  <= ramp_d;
      hi_q    <= hi_d;
      lo_q    <= lo_d;
      fltn_q  <= fltn_d;
    end
  end

  always_comb
  begin
    status                        = 32'h0000_0000;
    status[STAT_STALL]            = stall_q;
    status[STAT_REG_BRAKE]        = (st_q == RS_BRAKE);
    status[STAT_BLANKING]         = blk.busy;
    status[STAT_STALL_OFF]        = (st_q == RS_STALL_OFF);
    status[STAT_BRIDGE_LO +: 2]   = cmd;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY_OUT   = awrdy_q;
  assign S_AXI_WREADY_OUT    = wrdy_q;
  assign S_AXI_BVALID_OUT    = bvalid_q;
  assign S_AXI_BRESP_OUT     = bresp_q;
  assign S_AXI_ARREADY_OUT   = arrdy_q;
  assign S_AXI_RVALID_OUT    = rvalid_q;
  assign S_AXI_RDATA_OUT     = rdata_q;
  assign S_AXI_RRESP_OUT     = rresp_q;
  assign BRIDGE_HI_OUT       = hi_q;
  assign BRIDGE_LO_OUT       = lo_q;
  assign FAULT_OUT_N_OUT     = fltn_q;
  assign SOFTSTART_LEVEL_OUT = ramp_q;

endmodule // ccsd_top

// [include/ccsd_pkg.sv]
package ccsd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned BLANK_BASE_NS    = 5000000;
  localparam int unsigned BLANK_LSB_NS     = 102400;
  localparam int unsigned BLANK_BASE_CYC   = (BLANK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_LSB_CYC    = (BLANK_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_BLANK       = 8'h04;
  localparam logic [7:0]  ADDR_CMD         = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0c;

  // Control register fields.
  localparam int unsigned CTRL_SOFT_A      = 0;
  localparam int unsigned CTRL_SOFT_B      = 1;
  localparam int unsigned CTRL_REG_REP     = 2;
  localparam int unsigned CTRL_STALL_EN    = 3;
  localparam int unsigned CTRL_INT_REF     = 4;
  localparam int unsigned CTRL_BLK_RESP    = 5;
  localparam int unsigned CTRL_BLK_REP     = 6;
  localparam int unsigned CTRL_MODE_LO     = 8;
  localparam int unsigned CTRL_CBC_EN      = 10;
  localparam int unsigned CTRL_SS_EN       = 11;
  localparam int unsigned CTRL_SLEEP       = 12;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0600;

  // Blanking register fields.
  localparam int unsigned BLANK_SET_LO     = 0;
  localparam int unsigned BLANK_MULT_LO    = 16;
  localparam logic [31:0] BLANK_RESET      = 32'h0000_25f5;

  // Command register fields.
  localparam int unsigned CMD_CLR_FAULT    = 0;

  // Status register fields.
  localparam int unsigned STAT_STALL       = 0;
  localparam int unsigned STAT_REG_BRAKE   = 1;
  localparam int unsigned STAT_BLANKING    = 2;
  localparam int unsigned STAT_STALL_OFF   = 3;
  localparam int unsigned STAT_BRIDGE_LO   = 4;

  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_INRUSH      = 2'h1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BR_COAST = 2'b00,
    BR_FWD   = 2'b01,
    BR_REV   = 2'b10,
    BR_BRAKE = 2'b11
  } ccsd_bridge_t;

  typedef enum logic [1:0] {
    RS_FOLLOW    = 2'b00,
    RS_BRAKE     = 2'b01,
    RS_STALL_OFF = 2'b10
  } ccsd_reg_state_t;

endpackage

// [include/ccsd_blank_if.sv]
`timescale 1ns/1ps
interface ccsd_blank_if;
  logic        start;
  logic [15:0] setting;
  logic        busy;
  logic        tick;

  modport timer (input start, input setting, output busy, output tick);
  modport user  (output start, output setting, input busy, input tick);
endinterface

// [src/ccsd_blank_timer.sv]
`timescale 1ns/1ps
module ccsd_blank_timer
  import ccsd_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = BLANK_BASE_CYC,
  parameter int unsigned LSB_CYCLES  = BLANK_LSB_CYC
)
(
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  // Blanking control
  ccsd_blank_if.timer blk
);

  localparam int unsigned MAXC = (BASE_CYCLES > LSB_CYCLES) ? BASE_CYCLES : LSB_CYCLES;
  localparam int unsigned CW   = $clog2(MAXC + 1);

  logic          busy_q,  busy_d;
  logic          base_q,  base_d;
  logic          tick_q,  tick_d;
  logic [CW-1:0] cyc_q,   cyc_d;
  logic [15:0]   left_q,  left_d;
  logic [CW-1:0] limit;

  // ----------------------------------------------------------------
  // Interval: a fixed base, then one step per setting count.
  // ----------------------------------------------------------------
  always_comb
  begin
    busy_d = busy_q;
    base_d = base_q;
    cyc_d  = cyc_q;
    left_d = left_q;
    tick_d = 1'b0;
    limit  = base_q ? CW'(BASE_CYCLES - 1) : CW'(LSB_CYCLES - 1);
    if (blk.start)
    begin
      busy_d = 1'b1;
      base_d = 1'b1;
      cyc_d  = '0;
    end
    else if (busy_q)
    begin
      if (cyc_q == limit)
      begin
        cyc_d = '0;
        if (base_q)
        begin
          base_d = 1'b0;
          left_d = blk.setting;
          busy_d = (blk.setting != 16'h0000);
        end
        else
        begin
          tick_d = 1'b1;
          left_d = left_q - 16'h0001;
          busy_d = (left_q != 16'h0001);
        end
      end
      else
      begin
        cyc_d = cyc_q + CW'(1);
      end
    end
  end

  // Power-up counts as a start, so blanking runs straight out of reset.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_q <= 1'b1;
      base_q <= 1'b1;
      tick_q <= 1'b0;
      cyc_q  <= '0;
      left_q <= 16'h0000;
    end
    else
    begin
      busy_q <= busy_d;
      base_q <= base_d;
      tick_q <= tick_d;
      cyc_q  <= cyc_d;
      left_q <= left_d;
    end
  end

  assign blk.busy = busy_q;
  assign blk.tick = tick_q;

endmodule // ccsd_blank_timer

// [src/ccsd_ctrl_edge.sv]
`timescale 1ns/1ps
module ccsd_ctrl_edge
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control sources
  input  wire logic pin_a_in,
  input  wire logic pin_b_in,
  input  wire logic bit_a_in,
  input  wire logic bit_b_in,
  // Event
  output logic      edge_out
);

  logic [3:0] prev_q, prev_d;

  always_comb
  begin
    prev_d   = {bit_b_in, bit_a_in, pin_b_in, pin_a_in};
    // Pins count on either edge, register bits only on a rise.
    edge_out = (pin_a_in != prev_q[0]) | (pin_b_in != prev_q[1])
             | (bit_a_in & ~prev_q[2]) | (bit_b_in & ~prev_q[3]);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prev_q <= 4'h0;
    else
      prev_q <= prev_d;
  end

endmodule // ccsd_ctrl_edge

// [bench/ccsd_ctl_model.sv]
`timescale 1ns/1ps
module ccsd_ctl_model
(
  // Command from the bench and fault pin from the device
  input  wire logic [1:0] cmd_in,
  input  wire logic       fault_n_in,
  // Pins and fault reading
  output logic            pin_a_out,
  output logic            pin_b_out,
  output logic            dev_fault_out
);
  // ----------------------------------------------------------------
  // Controller pins
  // ----------------------------------------------------------------
  assign pin_a_out = cmd_in[0];
  assign pin_b_out = cmd_in[1];
  // A low fault pin under pin coast or brake is read as a device fault, though a soft control bit that drives can still make it the regulation flag.
  assign dev_fault_out = !fault_n_in && (cmd_in == 2'h0 || cmd_in == 2'h3);
endmodule // ccsd_ctl_model

// [bench/ccsd_chk_props.sv]
`timescale 1ns/1ps
module ccsd_chk
(
  // Clock and reset
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  // Bus handshakes
  input wire logic        S_AXI_AWVALID_IN,
  input wire logic        S_AXI_AWREADY_OUT,
  input wire logic        S_AXI_WVALID_IN,
  input wire logic        S_AXI_WREADY_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_ARVALID_IN,
  input wire logic        S_AXI_ARREADY_OUT,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  // Motor side
  input wire logic        DRIVE_INPUT_A_IN,
  input wire logic        DRIVE_INPUT_B_IN,
  input wire logic        TRIP_IN,
  input wire logic [1:0]  BRIDGE_HI_OUT,
  input wire logic [1:0]  BRIDGE_LO_OUT,
  input wire logic        FAULT_OUT_N_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  reset_idle_a: assert property (disable iff (1'b0) !RST_N_IN ##1 !RST_N_IN |->
    BRIDGE_HI_OUT == 2'h0 && BRIDGE_LO_OUT == 2'h0 && FAULT_OUT_N_OUT)
    else $error("bridge or fault active in reset");
  write_resp_a: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT &&
    S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##2 S_AXI_BVALID_OUT)
    else $error("write response late");
  read_resp_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read response late");
  bresp_done_a: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
    else $error("write response repeated");
  rresp_done_a: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
    else $error("read response repeated");
  trip_brake_a: assert property (TRIP_IN && {DRIVE_INPUT_B_IN, DRIVE_INPUT_A_IN} == 2'h1 &&
    $stable({DRIVE_INPUT_B_IN, DRIVE_INPUT_A_IN}) |=> BRIDGE_LO_OUT == 2'h3)
    else $error("trip did not brake");
  brake_hold_a: assert property (BRIDGE_LO_OUT == 2'h3 && S_AXI_AWREADY_OUT &&
    {DRIVE_INPUT_B_IN, DRIVE_INPUT_A_IN} == 2'h1 && !S_AXI_BVALID_OUT &&
    $stable({DRIVE_INPUT_B_IN, DRIVE_INPUT_A_IN}) |=> BRIDGE_HI_OUT != 2'h1)
    else $error("brake left without edge");
  idle_flag_a: assert property (TRIP_IN && BRIDGE_HI_OUT == 2'h0 && FAULT_OUT_N_OUT
    |=> FAULT_OUT_N_OUT)
    else $error("regulation flag outside drive");
endmodule // ccsd_chk

bind ccsd_top ccsd_chk u_chk (.CLK_IN, .RST_N_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
  .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
  .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN,
  .DRIVE_INPUT_A_IN, .DRIVE_INPUT_B_IN, .TRIP_IN, .BRIDGE_HI_OUT, .BRIDGE_LO_OUT,
  .FAULT_OUT_N_OUT);

// [bench/cbc_current_reg_stall_detect_bench.sv]
`timescale 1ns/1ps
module cbc_current_reg_stall_detect_bench;
  import ccsd_pkg::*;
  logic        clk;
  logic        rst_n = 1'b0;
  logic        awv   = 1'b0;
  logic        wv    = 1'b0;
  logic        arv   = 1'b0;
  logic        trip  = 1'b0;
  logic        s_ext = 1'b0;
  logic        s_int = 1'b0;
  logic [1:0]  cmd   = 2'h0;
  logic [7:0]  awa   = 8'h00;
  logic [7:0]  ara   = 8'h00;
  logic [31:0] wd    = 32'h0;
  logic [31:0] rdat, rdv;
  logic [15:0] lvl;
  logic [1:0]  bresp, rresp, rsp, hi, lo;
  logic        awr, wrdy, bv, arr, rv, pa, pb, fault_n, dev_fault;
  int          fails = 0;
  int          cmp_count = 0;
  logic [5:0]  rows [4] = '{6'h00, 6'h16, 6'h29, 6'h33};

  ccsd_top #(.BASE_CYCLES(20), .LSB_CYCLES(4)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(1'b1), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(1'b1), .DRIVE_INPUT_A_IN(pa),
    .DRIVE_INPUT_B_IN(pb), .TRIP_IN(trip), .SENSE_GE_EXT_REF_IN(s_ext),
    .SENSE_GE_INT_REF_IN(s_int), .BRIDGE_HI_OUT(hi), .BRIDGE_LO_OUT(lo),
    .FAULT_OUT_N_OUT(fault_n), .SOFTSTART_LEVEL_OUT(lvl));
  ccsd_ctl_model u_ctl (.cmd_in(cmd), .fault_n_in(fault_n), .pin_a_out(pa),
    .pin_b_out(pb), .dev_fault_out(dev_fault));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cb(input logic [3:0] e);
    chk("bridge", {28'h0, e}, {28'h0, hi, lo});
  endtask
  task automatic cf(input logic e);
    chk("fault", {31'h0, e}, {31'h0, fault_n});
  endtask
  task automatic cs(input logic [31:0] e);
    rd(ADDR_STATUS);
    chk("status", e, rdv & 32'h3f);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    if (bv !== 1'b1) tmo();
    rsp = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    repeat (40)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    if (rv !== 1'b1) tmo();
    rdv = rdat;
    rsp = rresp;
  endtask
  task automatic wblank();
    repeat (100)
    begin
      rd(ADDR_STATUS);
      if (rdv[STAT_BLANKING] === 1'b0) break;
    end
    if (rdv[STAT_BLANKING] !== 1'b0) tmo();
  endtask
  task automatic pulse();
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    cb(4'h0);
    cf(1'b1);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL);
    chk("ctrl", CTRL_RESET, rdv);
    rd(ADDR_BLANK);
    chk("blank", BLANK_RESET, rdv);
    rd(8'h10);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(8'h10, 32'h1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("registers done");
    foreach (rows[i])
    begin
      cmd <= rows[i][5:4];
      repeat (3) @(posedge clk);
      cb(rows[i][3:0]);
    end
    $display("rows done");
    wr(ADDR_CTRL, 32'h604);
    cmd <= 2'h1;
    repeat (3) @(posedge clk);
    pulse();
    cb(4'h3);
    cf(1'b0);
    repeat (20) @(posedge clk);
    cb(4'h3);
    cmd <= 2'h2;
    repeat (3) @(posedge clk);
    cb(4'h9);
    cf(1'b1);
    cmd <= 2'h0;
    repeat (3) @(posedge clk);
    pulse();
    cb(4'h0);
    cf(1'b1);
    chk("dev_fault", 32'h0, {31'h0, dev_fault});
    wr(ADDR_CTRL, 32'h605);
    repeat (3) @(posedge clk);
    pulse();
    cb(4'h3);
    wr(ADDR_CTRL, 32'h604);
    repeat (3) @(posedge clk);
    cb(4'h3);
    wr(ADDR_CTRL, 32'h605);
    repeat (3) @(posedge clk);
    cb(4'h6);
    $display("regulation done");
    cmd <= 2'h1;
    wr(ADDR_CTRL, 32'h58);
    wr(ADDR_BLANK, 32'h0);
    s_int <= 1'b1;
    wr(ADDR_CMD, 32'h1);
    cs(32'h14);
    wblank();
    repeat (2) @(posedge clk);
    cs(32'h19);
    cb(4'h0);
    cf(1'b0);
    wr(ADDR_CTRL, 32'h28);
    wr(ADDR_CMD, 32'h1);
    repeat (3) @(posedge clk);
    cs(32'h14);
    wblank();
    cs(32'h10);
    s_ext <= 1'b1;
    repeat (3) @(posedge clk);
    cs(32'h11);
    cb(4'h6);
    cf(1'b1);
    chk("level", 32'hffff, {16'h0, lvl});
    wr(ADDR_CTRL, 32'h20);
    wr(ADDR_CMD, 32'h1);
    wblank();
    repeat (3) @(posedge clk);
    cs(32'h10);
    $display("stall done");
    wr(ADDR_CTRL, 32'h1020);
    repeat (2) @(posedge clk);
    cb(4'h0);
    wr(ADDR_CTRL, 32'h20);
    cs(32'h14);
    wblank();
    wr(ADDR_CTRL, 32'h504);
    pulse();
    cb(4'h3);
    wr(ADDR_CTRL, 32'h52c);
    cmd <= 2'h2;
    repeat (3) @(posedge clk);
    pulse();
    cb(4'h9);
    $display("modes done");
    complete_run();
  end
endmodule // cbc_current_reg_stall_detect_bench
